// file: core/lcdc_setup.v
`timescale 1ns/1ps
`default_nettype none
`include "lcdc_defs.vh"

module lcdc_setup (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_b,
    // Host write port pins
    input  wire        cs_b,
    input  wire        wr_b,
    input  wire        cmd_param_select,
    input  wire [7:0]  host_data,
    // Host transfer status
    output wire [7:0]  cmd_code,
    output wire [3:0]  param_index,
    output wire        cfg_write_pulse,
    // Line and frame geometry
    output wire [3:0]  char_height_field,
    output wire [7:0]  line_addr_count,
    output wire [7:0]  line_total_field,
    output wire [7:0]  frame_line_count,
    output wire [15:0] virtual_width_field,
    // Screen blocks
    output wire [15:0] block1_start,
    output wire [7:0]  block1_lines,
    output wire [15:0] block2_start,
    output wire [7:0]  block2_lines,
    output wire [15:0] block3_start,
    output wire [15:0] block4_start,
    // Shift and overlay
    output wire [2:0]  pixel_shift_cmd,
    output wire [1:0]  combine_method,
    output wire        block1_text_sel,
    output wire        block3_text_sel
);

    localparam REG_BITS = 8 * `LCDC_REG_COUNT;

    // Pin synchronisers, first stage read only by the second
    reg        cs_s1_reg;
    reg        cs_s2_reg;
    reg        wr_s1_reg;
    reg        wr_s2_reg;
    reg        sel_s1_reg;
    reg        sel_s2_reg;
    reg  [7:0] data_s1_reg;
    reg  [7:0] data_s2_reg;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_s1_reg   <= 1'b1;
            cs_s2_reg   <= 1'b1;
            wr_s1_reg   <= 1'b1;
            wr_s2_reg   <= 1'b1;
            sel_s1_reg  <= 1'b0;
            sel_s2_reg  <= 1'b0;
            data_s1_reg <= 8'h00;
            data_s2_reg <= 8'h00;
        end else begin
            cs_s1_reg   <= cs_b;
            cs_s2_reg   <= cs_s1_reg;
            wr_s1_reg   <= wr_b;
            wr_s2_reg   <= wr_s1_reg;
            sel_s1_reg  <= cmd_param_select;
            sel_s2_reg  <= sel_s1_reg;
            data_s1_reg <= host_data;
            data_s2_reg <= data_s1_reg;
        end
    end

    // Write cycle tracking
    // The byte and select are taken while the strobe is low, so a host that
    // changes data right at the strobe's rising edge is still caught cleanly.
    wire       wr_active = ~cs_s2_reg & ~wr_s2_reg;
    reg        wr_active_d_reg;
    reg        hold_sel_reg;
    reg  [7:0] hold_data_reg;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_active_d_reg <= 1'b0;
            hold_sel_reg    <= 1'b0;
            hold_data_reg   <= 8'h00;
        end else begin
            wr_active_d_reg <= wr_active;
            if (wr_active) begin
                hold_sel_reg  <= sel_s2_reg;
                hold_data_reg <= data_s2_reg;
            end
        end
    end

    wire wr_done    = wr_active_d_reg & ~wr_active;
    wire cmd_write  = wr_done & hold_sel_reg;
    wire prm_write  = wr_done & ~hold_sel_reg;

    // Command and parameter index
    reg  [7:0] cmd_code_reg;
    reg  [7:0] cmd_code_next;
    reg  [3:0] param_idx_reg;
    reg  [3:0] param_idx_next;

    always @* begin
        cmd_code_next  = cmd_code_reg;
        param_idx_next = param_idx_reg;
        if (cmd_write) begin
            cmd_code_next  = hold_data_reg;
            param_idx_next = 4'h0;
        end else if (prm_write && param_idx_reg != `LCDC_IDX_MAX) begin
            param_idx_next = param_idx_reg + 4'h1;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_code_reg  <= 8'h00;
            param_idx_reg <= 4'h0;
        end else begin
            cmd_code_reg  <= cmd_code_next;
            param_idx_reg <= param_idx_next;
        end
    end

    // Register steering
    wire [4:0] seq_addr;
    wire       seq_hit;

    lcdc_param_seq u_seq (
        .cmd_code  (cmd_code_reg),
        .param_idx (param_idx_reg),
        .reg_addr  (seq_addr),
        .reg_hit   (seq_hit)
    );

    // Extra bytes past a command's sequence, and bytes for unknown commands,
    // are dropped so a runaway host cannot clobber neighbouring registers.
    wire       reg_we = prm_write & seq_hit;

    reg        write_pulse_reg;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            write_pulse_reg <= 1'b0;
        end else begin
            write_pulse_reg <= reg_we;
        end
    end

    // Configuration register file, only the mapped offsets hold flops
    wire [REG_BITS-1:0] cfg_flat;

    genvar gi;
    generate
        for (gi = 0; gi < `LCDC_REG_COUNT; gi = gi + 1) begin : g_cfg
            localparam [31:0] IMPL  = `LCDC_REG_IMPL_MASK;
            localparam [4:0]  INDEX = gi;
            if (IMPL[gi]) begin : g_reg
                reg [7:0] val_reg;
                always @(posedge clk or negedge rst_b) begin
                    if (!rst_b) begin
                        val_reg <= `LCDC_REG_RESET;
                    end else if (reg_we && seq_addr == INDEX) begin
                        val_reg <= hold_data_reg;
                    end
                end
                assign cfg_flat[gi*8 +: 8] = val_reg;
            end else begin : g_none
                assign cfg_flat[gi*8 +: 8] = 8'h00;
            end
        end
    endgenerate

    // Status outputs
    assign cmd_code        = cmd_code_reg;
    assign param_index     = param_idx_reg;
    assign cfg_write_pulse = write_pulse_reg;

    // Line and frame geometry; values are stored as count minus one where noted
    assign char_height_field =
        cfg_flat[`LCDC_REG_CHAR_HEIGHT*8 +: `LCDC_CHAR_HEIGHT_MSB+1];
    assign line_addr_count   = cfg_flat[`LCDC_REG_LINE_ADDR*8 +: 8];
    assign line_total_field  = cfg_flat[`LCDC_REG_LINE_TOTAL*8 +: 8];
    assign frame_line_count  = cfg_flat[`LCDC_REG_FRAME_LINES*8 +: 8];
    assign virtual_width_field = {cfg_flat[`LCDC_REG_VWIDTH_HI*8 +: 8],
                                  cfg_flat[`LCDC_REG_VWIDTH_LO*8 +: 8]};

    // Screen blocks, low byte arrives first
    assign block1_start = {cfg_flat[`LCDC_REG_B1_START_HI*8 +: 8],
                           cfg_flat[`LCDC_REG_B1_START_LO*8 +: 8]};
    assign block1_lines = cfg_flat[`LCDC_REG_B1_LINES*8 +: 8];
    assign block2_start = {cfg_flat[`LCDC_REG_B2_START_HI*8 +: 8],
                           cfg_flat[`LCDC_REG_B2_START_LO*8 +: 8]};
    assign block2_lines = cfg_flat[`LCDC_REG_B2_LINES*8 +: 8];
    assign block3_start = {cfg_flat[`LCDC_REG_B3_START_HI*8 +: 8],
                           cfg_flat[`LCDC_REG_B3_START_LO*8 +: 8]};
    assign block4_start = {cfg_flat[`LCDC_REG_B4_START_HI*8 +: 8],
                           cfg_flat[`LCDC_REG_B4_START_LO*8 +: 8]};

    // Shift and overlay fields
    assign pixel_shift_cmd =
        cfg_flat[`LCDC_REG_PIX_SHIFT*8 +: `LCDC_PIX_SHIFT_MSB+1];
    assign combine_method  =
        cfg_flat[`LCDC_REG_LAYER_CTRL*8 +: `LCDC_COMBINE_MSB+1];
    assign block1_text_sel =
        cfg_flat[`LCDC_REG_LAYER_CTRL*8 + `LCDC_B1_TEXT_BIT];
    assign block3_text_sel =
        cfg_flat[`LCDC_REG_LAYER_CTRL*8 + `LCDC_B3_TEXT_BIT];

endmodule // lcdc_setup
`default_nettype wire

// file: core/lcdc_defs.vh
`ifndef LCDC_DEFS_VH
`define LCDC_DEFS_VH

// Command codes
`define LCDC_CMD_SYS_SET     8'h40
`define LCDC_CMD_SCROLL      8'h44
`define LCDC_CMD_PIX_SHIFT   8'h5A
`define LCDC_CMD_LAYER       8'h5B

// Register offsets
`define LCDC_REG_CHAR_HEIGHT 5'h02
`define LCDC_REG_LINE_ADDR   5'h03
`define LCDC_REG_LINE_TOTAL  5'h04
`define LCDC_REG_FRAME_LINES 5'h05
`define LCDC_REG_VWIDTH_LO   5'h06
`define LCDC_REG_VWIDTH_HI   5'h07
`define LCDC_REG_B1_START_LO 5'h0B
`define LCDC_REG_B1_START_HI 5'h0C
`define LCDC_REG_B1_LINES    5'h0D
`define LCDC_REG_B2_START_LO 5'h0E
`define LCDC_REG_B2_START_HI 5'h0F
`define LCDC_REG_B2_LINES    5'h10
`define LCDC_REG_B3_START_LO 5'h11
`define LCDC_REG_B3_START_HI 5'h12
`define LCDC_REG_B4_START_LO 5'h13
`define LCDC_REG_B4_START_HI 5'h14
`define LCDC_REG_LAYER_CTRL  5'h18
`define LCDC_REG_PIX_SHIFT   5'h1B

// Register space
`define LCDC_REG_COUNT       32
`define LCDC_REG_IMPL_MASK   32'h091FF8FC
`define LCDC_REG_RESET       8'h00

// Parameter sequences: first stored index of system set, last index of system set and scroll
`define LCDC_SYS_FIRST_IDX   4'h2
`define LCDC_SYS_LAST_IDX    4'h7
`define LCDC_SCROLL_LAST_IDX 4'h9
`define LCDC_IDX_MAX         4'hF

// Field positions
`define LCDC_CHAR_HEIGHT_MSB 3
`define LCDC_PIX_SHIFT_MSB   2
`define LCDC_COMBINE_MSB     1
`define LCDC_B1_TEXT_BIT     2
`define LCDC_B3_TEXT_BIT     3

`endif

// file: core/lcdc_param_seq.v
`timescale 1ns/1ps
`default_nettype none
`include "lcdc_defs.vh"

module lcdc_param_seq (
    // Current command and parameter position
    input  wire [7:0] cmd_code,
    input  wire [3:0] param_idx,
    // Target register
    output reg  [4:0] reg_addr,
    output reg        reg_hit
);

    always @* begin
        reg_addr = 5'h00;
        reg_hit  = 1'b0;
        case (cmd_code)
            `LCDC_CMD_SYS_SET: begin
                // The first two bytes feed fields outside this block and are dropped
                if (param_idx >= `LCDC_SYS_FIRST_IDX && param_idx <= `LCDC_SYS_LAST_IDX) begin
                    reg_addr = {1'b0, param_idx};
                    reg_hit  = 1'b1;
                end
            end
            `LCDC_CMD_SCROLL: begin
                if (param_idx <= `LCDC_SCROLL_LAST_IDX) begin
                    reg_addr = `LCDC_REG_B1_START_LO + {1'b0, param_idx};
                    reg_hit  = 1'b1;
                end
            end
            `LCDC_CMD_PIX_SHIFT: begin
                if (param_idx == 4'h0) begin
                    reg_addr = `LCDC_REG_PIX_SHIFT;
                    reg_hit  = 1'b1;
                end
            end
            `LCDC_CMD_LAYER: begin
                if (param_idx == 4'h0) begin
                    reg_addr = `LCDC_REG_LAYER_CTRL;
                    reg_hit  = 1'b1;
                end
            end
            default: begin
                reg_addr = 5'h00;
                reg_hit  = 1'b0;
            end
        endcase
    end

endmodule // lcdc_param_seq
`default_nettype wire

// file: sim/lcdc_setup_sva.sv
`timescale 1ns/1ps
`default_nettype none
module lcdc_setup_sva (
    // Clock, reset and host pins
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        cs_b,
    input wire logic        wr_b,
    input wire logic        cmd_param_select,
    input wire logic [7:0]  host_data,
    // Status and fields
    input wire logic [7:0]  cmd_code,
    input wire logic [3:0]  param_index,
    input wire logic        cfg_write_pulse,
    input wire logic [3:0]  char_height_field,
    input wire logic [15:0] block1_start,
    input wire logic [2:0]  pixel_shift_cmd,
    input wire logic [1:0]  combine_method,
    input wire logic        block1_text_sel,
    input wire logic        block3_text_sel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Strobe seen to end while selected
    sequence s_end;
        $rose(wr_b) && !cs_b;
    endsequence
    sequence s_par(c, i);
        s_end ##0 (!cmd_param_select && cmd_code == c && param_index == i);
    endsequence
    a_cmd_taken: assert property (s_end ##0 cmd_param_select |-> ##3
        (cmd_code == $past(host_data, 3) && param_index == 4'h0)) else $error("command not taken");
    a_index_step: assert property (s_end ##0 !cmd_param_select |-> ##3
        param_index == (($past(param_index, 3) == 4'hF) ? 4'hF : $past(param_index, 3) + 4'h1))
        else $error("parameter index wrong");
    a_height_load: assert property (s_par(8'h40, 4'h2) |-> ##3
        char_height_field == $past(host_data[3:0], 3)) else $error("height wrong");
    a_b1_low: assert property (s_par(8'h44, 4'h0) |-> ##3
        block1_start[7:0] == $past(host_data, 3)) else $error("block1 low wrong");
    a_b1_high: assert property (s_par(8'h44, 4'h1) |-> ##3
        (block1_start[15:8] == $past(host_data, 3) && $stable(block1_start[7:0])))
        else $error("block1 high wrong");
    a_shift_load: assert property (s_par(8'h5A, 4'h0) |-> ##3
        (pixel_shift_cmd == $past(host_data[2:0], 3) && cfg_write_pulse))
        else $error("shift wrong");
    a_layer_load: assert property (s_par(8'h5B, 4'h0) |-> ##3
        {block3_text_sel, block1_text_sel, combine_method} == $past(host_data[3:0], 3))
        else $error("overlay wrong");
    a_extra_ignored: assert property (s_par(8'h5A, 4'h1) |-> ##1
        (!cfg_write_pulse && $stable(pixel_shift_cmd))[*5]) else $error("extra byte stored");
endmodule // lcdc_setup_sva
bind lcdc_setup lcdc_setup_sva u_sva (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .wr_b(wr_b),
    .cmd_param_select(cmd_param_select), .host_data(host_data), .cmd_code(cmd_code),
    .param_index(param_index), .cfg_write_pulse(cfg_write_pulse),
    .char_height_field(char_height_field), .block1_start(block1_start),
    .pixel_shift_cmd(pixel_shift_cmd), .combine_method(combine_method),
    .block1_text_sel(block1_text_sel), .block3_text_sel(block3_text_sel));
`default_nettype wire

// file: sim/lcdc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcdc_host_model (
    // Host write pins
    input  wire logic  clk,
    output logic       cs_b,
    output logic       wr_b,
    output logic       sel,
    output logic [7:0] data
);
    initial begin
        cs_b = 1'b1;
        wr_b = 1'b1;
        sel = 1'b0;
        data = 8'h5A;
    end
    task automatic write(input logic is_cmd, input logic [7:0] d);
        @(posedge clk);
        cs_b <= 1'b0;
        sel <= is_cmd;
        data <= d;
        wr_b <= 1'b0;
        repeat (2) @(posedge clk);
        wr_b <= 1'b1;
        @(posedge clk);
        // Deselected pins must not look like the last byte
        cs_b <= 1'b1;
        sel <= ~is_cmd;
        data <= ~d;
        repeat (5) @(posedge clk);
    endtask
endmodule // lcdc_host_model
`default_nettype wire

// file: sim/lcdc_setup_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lcdc_setup_tb;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    wire         cs_b, wr_b, sel, pulse, b1_txt, b3_txt;
    wire  [7:0]  data, cmd_code, line_addr, line_total, frame_lines, b1_lines, b2_lines;
    wire  [3:0]  param_index, char_height;
    wire  [15:0] vwidth, b1_start, b2_start, b3_start, b4_start;
    wire  [2:0]  shift;
    wire  [1:0]  combine;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          n_pulses = 0;
    always #12.5 clk = ~clk;
    // Counts register updates so dropped bytes can be told from stored ones
    always @(posedge clk) if (pulse === 1'b1) n_pulses <= n_pulses + 1;
    lcdc_host_model u_host (.clk(clk), .cs_b(cs_b), .wr_b(wr_b), .sel(sel), .data(data));
    lcdc_setup u_dut (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .wr_b(wr_b),
        .cmd_param_select(sel), .host_data(data), .cmd_code(cmd_code),
        .param_index(param_index), .cfg_write_pulse(pulse), .char_height_field(char_height),
        .line_addr_count(line_addr), .line_total_field(line_total),
        .frame_line_count(frame_lines), .virtual_width_field(vwidth), .block1_start(b1_start),
        .block1_lines(b1_lines), .block2_start(b2_start), .block2_lines(b2_lines),
        .block3_start(b3_start), .block4_start(b4_start), .pixel_shift_cmd(shift),
        .combine_method(combine), .block1_text_sel(b1_txt), .block3_text_sel(b3_txt));
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic send(input logic [7:0] c, input logic [7:0] p[$]);
        u_host.write(1'b1, c);
        foreach (p[i]) u_host.write(1'b0, p[i]);
    endtask
    task automatic t_reset;
        chk("cmd_code", 16'h0000, {8'h00, cmd_code});
        chk("vwidth", 16'h0000, vwidth);
        $display("test reset done");
    endtask
    task automatic t_sys_set;
        // Trailing byte lies past the sequence
        send(8'h40, '{8'h38, 8'h87, 8'h07, 8'h3F, 8'h49, 8'h7F, 8'h80, 8'h00, 8'h5C});
        chk("char_height", 16'h0007, {12'h000, char_height});
        chk("line_addr", 16'h003F, {8'h00, line_addr});
        chk("line_total", 16'h0049, {8'h00, line_total});
        chk("frame_lines", 16'h007F, {8'h00, frame_lines});
        chk("vwidth", 16'h0080, vwidth);
        chk("param_index", 16'h0009, {12'h000, param_index});
        chk("write_pulses", 16'h0006, n_pulses[15:0]);
        $display("test system set done");
    endtask
    task automatic t_scroll;
        send(8'h44, '{8'h21, 8'h43, 8'h40, 8'h65, 8'h10, 8'h41, 8'h87, 8'h04, 8'hA9, 8'h30, 8'h77});
        chk("b1_start", 16'h4321, b1_start);
        chk("b1_lines", 16'h0040, {8'h00, b1_lines});
        chk("b2_start", 16'h1065, b2_start);
        chk("b2_lines", 16'h0041, {8'h00, b2_lines});
        chk("b3_start", 16'h0487, b3_start);
        chk("b4_start", 16'h30A9, b4_start);
        $display("test scroll done");
    endtask
    task automatic t_shift_layer;
        logic [7:0] v[4] = '{8'h01, 8'h06, 8'h0B, 8'h0C};
        send(8'h5A, '{8'hFD, 8'h02});
        chk("shift", 16'h0005, {13'h0000, shift});
        foreach (v[i]) begin
            send(8'h5B, '{v[i]});
            chk("combine", {14'h0000, v[i][1:0]}, {14'h0000, combine});
            chk("b1_txt", {15'h0000, v[i][2]}, {15'h0000, b1_txt});
            chk("b3_txt", {15'h0000, v[i][3]}, {15'h0000, b3_txt});
        end
        $display("test shift and overlay done");
    endtask
    task automatic t_switch;
        send(8'h44, '{8'h5E});
        send(8'h5A, '{8'h03});
        chk("b1_start", 16'h435E, b1_start);
        chk("shift", 16'h0003, {13'h0000, shift});
        $display("test command switch done");
    endtask
    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_sys_set();
        t_scroll();
        t_shift_layer();
        t_switch();
        print_verdict();
    end
endmodule // lcdc_setup_tb
`default_nettype wire
